// File: rtl/ppl_map.svh
// ppl_map.svh: register addresses, patch block layout and field positions
// for the patch loader. Definitions only; included by bare name.
`ifndef PPL_MAP_SVH
`define PPL_MAP_SVH

// model register addresses
`define PPL_TRIG_ADDR    32'h0000_0079
`define PPL_SIG_ADDR     32'h0000_008B

// patch block layout, in bytes
`define PPL_BLOCK_BYTES  32'h0000_0800
`define PPL_HDR_BYTES    32'h0000_0030
`define PPL_REV_OFS      32'h0000_0004
// distance from the data start back to the header revision field
`define PPL_REV_BACK     (`PPL_HDR_BYTES - `PPL_REV_OFS)

// word counts and the byte step from one word to the next
`define PPL_DATA_WORDS   9'h1F4
`define PPL_ONE_WORD     9'h001
`define PPL_WORD_STEP    32'h0000_0004

// signature layout: revision sits in the upper half
`define PPL_SIG_REV_MSB  63
`define PPL_SIG_REV_LSB  32

`endif

// File: rtl/ppl_pkg.sv
// ppl_pkg: types shared by the patch loader files.
// assumes ppl_map.svh supplies the numeric constants.
package ppl_pkg;

    typedef enum logic [1:0] {
        PPL_IDLE,
        PPL_PRIME,
        PPL_STREAM
    } ppl_state_e;

    // one model register access from the core, at most one of wr/rd set
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [63:0] wdata;
    } ppl_mreg_req_s;

    // one patch data word handed to the microcode store
    typedef struct packed {
        logic        valid;
        logic [8:0]  index;
        logic [31:0] data;
    } ppl_ucode_wr_s;

endpackage : ppl_pkg

// File: rtl/ppl_align.sv
// ppl_align: picks a 32-bit word that starts at any byte of the lower of two
// consecutive aligned memory words (little-endian byte order).
// assumes lo_word is the lower-addressed word; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module ppl_align (
    // words
    input  wire logic [31:0] i_lo_word,
    input  wire logic [31:0] i_hi_word,
    // byte offset of the wanted word inside i_lo_word
    input  wire logic [1:0]  i_byte_ofs,
    // result
    output logic      [31:0] o_word
);

    logic [63:0] pair;

    always_comb begin
        pair = {i_hi_word, i_lo_word};
        case (i_byte_ofs)
            2'h0:    o_word = pair[31:0];
            2'h1:    o_word = pair[39:8];
            2'h2:    o_word = pair[47:16];
            2'h3:    o_word = pair[55:24];
            default: o_word = pair[31:0];
        endcase
    end

endmodule : ppl_align

`default_nettype wire

// File: rtl/ppl_sig.sv
// ppl_sig: the 64-bit patch revision signature register.
// assumes the core writes it through the model register port and pulses
// the identification query; only hard reset or a software write of zero clears it.
`timescale 1ns/1ps
`default_nettype none

`include "ppl_map.svh"

module ppl_sig (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // software write
    input  wire logic        i_wr,
    input  wire logic [63:0] i_wdata,
    // identification query and active patch state
    input  wire logic        i_query,
    input  wire logic        i_active,
    input  wire logic [31:0] i_rev,
    // register value
    output logic      [63:0] o_sig
);

    logic [63:0] sig_r;
    logic [63:0] sig_nxt;

    always_comb begin
        sig_nxt = sig_r;
        if (i_wr) begin
            sig_nxt = i_wdata;
        end
        // a query in the same cycle as a write lands last
        if (i_query && i_active) begin
            sig_nxt = '0;
            sig_nxt[`PPL_SIG_REV_MSB:`PPL_SIG_REV_LSB] = i_rev;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sig_r <= 64'h0000_0000_0000_0000;
        end else begin
            sig_r <= sig_nxt;
        end
    end

    assign o_sig = sig_r;

endmodule : ppl_sig

`default_nettype wire

// File: rtl/ppl_loader.sv
// ppl_loader: processor-side patch loader. A write to the trigger model
// register fetches a patch block from memory, hands the data words to the
// microcode store and makes the header revision the active one.
// assumes a one-request-at-a-time memory read port with a one-cycle ack,
// and that i_rst is the hard reset while i_soft_init is the INIT event.
//
// Notes on behaviour
// - trigger write loads the patch whose data starts at the written address
// - patch data may start at any byte address
// - hard reset discards the patch and its revision
// - soft init keeps the applied patch and its signature, except on the last data ack, where the new patch applies
// - loading the same patch again has no extra effect
// - identification query writes the active revision into the signature
// - with no patch active the query leaves the signature unchanged
// - signature upper half holds the header revision of the loaded patch
// - reading the signature never disturbs the active patch
// - no loaded patch counts as revision zero
// - a patch block is 2048 bytes: 48-byte header then data
// - header revision is the 4-byte field at byte offset 4
`timescale 1ns/1ps
`default_nettype none

`include "ppl_map.svh"

module ppl_loader
    import ppl_pkg::*;
(
    // clock and hard reset
    input  wire logic          i_clock,
    input  wire logic          i_rst,
    // soft initialization event
    input  wire logic          i_soft_init,
    // model register port and identification query
    input  wire ppl_mreg_req_s i_mreg,
    input  wire logic          i_ident_query,
    output logic               o_mreg_rvalid,
    output logic      [63:0]   o_mreg_rdata,
    output logic               o_mreg_fault,
    // memory read port, word-aligned byte addresses
    output logic               o_mem_req,
    output logic      [31:0]   o_mem_addr,
    input  wire logic          i_mem_ack,
    input  wire logic [31:0]   i_mem_rdata,
    // microcode store and status
    output ppl_ucode_wr_s      o_ucode_wr,
    output logic               o_busy,
    output logic               o_patch_active,
    output logic      [31:0]   o_patch_rev
);

    ppl_state_e    state_r,   state_nxt;
    logic          job_data_r, job_data_nxt;
    logic [31:0]   base_r,    base_nxt;
    logic [31:0]   addr_r,    addr_nxt;
    logic [1:0]    ofs_r,     ofs_nxt;
    logic [8:0]    left_r,    left_nxt;
    logic [31:0]   prev_r,    prev_nxt;
    logic [31:0]   hdr_rev_r, hdr_rev_nxt;
    logic          req_r,     req_nxt;
    ppl_ucode_wr_s ucode_r,   ucode_nxt;
    logic          active_r,  active_nxt;
    logic [31:0]   rev_r,     rev_nxt;
    logic          busy_r,    busy_nxt;
    logic          rvalid_r,  rvalid_nxt;
    logic [63:0]   rdata_r,   rdata_nxt;
    logic          fault_r,   fault_nxt;

    logic          trig_hit;
    logic          sig_hit;
    logic          sig_wr;
    logic [31:0]   rev_start;
    logic [31:0]   aligned_word;
    logic [63:0]   sig_val;

    assign trig_hit = i_mreg.addr == `PPL_TRIG_ADDR;
    assign sig_hit  = i_mreg.addr == `PPL_SIG_ADDR;
    assign sig_wr   = i_mreg.wr && sig_hit;
    // header revision field lies 44 bytes before the data start
    // taken straight from the written word so the next-state logic
    // does not read back its own output
    assign rev_start = i_mreg.wdata[31:0] - `PPL_REV_BACK;

    ppl_align u_align (
        .i_lo_word  (prev_r),
        .i_hi_word  (i_mem_rdata),
        .i_byte_ofs (ofs_r),
        .o_word     (aligned_word)
    );

    ppl_sig u_sig (
        .i_clock  (i_clock),
        .i_rst    (i_rst),
        .i_wr     (sig_wr),
        .i_wdata  (i_mreg.wdata),
        .i_query  (i_ident_query),
        .i_active (active_r),
        .i_rev    (rev_r),
        .o_sig    (sig_val)
    );

    // register port answers
    always_comb begin
        rvalid_nxt = 1'b0;
        rdata_nxt  = rdata_r;
        fault_nxt  = 1'b0;
        if (i_mreg.rd) begin
            rvalid_nxt = 1'b1;
            if (sig_hit) begin
                // a read only samples, nothing else changes
                rdata_nxt = sig_val;
            end else begin
                // the trigger is write-only; other addresses are not ours
                rdata_nxt = 64'h0000_0000_0000_0000;
                fault_nxt = 1'b1;
            end
        end else if (i_mreg.wr && !trig_hit && !sig_hit) begin
            fault_nxt = 1'b1;
        end
    end

    // fetch sequence: revision word first, then the data words
    always_comb begin
        state_nxt    = state_r;
        job_data_nxt = job_data_r;
        base_nxt     = base_r;
        addr_nxt     = addr_r;
        ofs_nxt      = ofs_r;
        left_nxt     = left_r;
        prev_nxt     = prev_r;
        hdr_rev_nxt  = hdr_rev_r;
        req_nxt      = req_r;
        active_nxt   = active_r;
        rev_nxt      = rev_r;
        ucode_nxt    = '0;
        case (state_r)
            PPL_IDLE: begin
                // only the low word of the written value is the address
                if (i_mreg.wr && trig_hit) begin
                    base_nxt     = i_mreg.wdata[31:0];
                    addr_nxt     = {rev_start[31:2], 2'h0};
                    ofs_nxt      = rev_start[1:0];
                    left_nxt     = `PPL_ONE_WORD;
                    job_data_nxt = 1'b0;
                    req_nxt      = 1'b1;
                    state_nxt    = PPL_PRIME;
                end
            end
            PPL_PRIME: begin
                if (i_mem_ack) begin
                    prev_nxt  = i_mem_rdata;
                    addr_nxt  = addr_r + `PPL_WORD_STEP;
                    state_nxt = PPL_STREAM;
                end
            end
            PPL_STREAM: begin
                if (i_mem_ack) begin
                    prev_nxt = i_mem_rdata;
                    addr_nxt = addr_r + `PPL_WORD_STEP;
                    left_nxt = left_r - `PPL_ONE_WORD;
                    if (job_data_r) begin
                        ucode_nxt.valid = 1'b1;
                        ucode_nxt.index = `PPL_DATA_WORDS - left_r;
                        ucode_nxt.data  = aligned_word;
                    end else begin
                        hdr_rev_nxt = aligned_word;
                    end
                    if (left_r == `PPL_ONE_WORD) begin
                        if (!job_data_r) begin
                            addr_nxt     = {base_r[31:2], 2'h0};
                            ofs_nxt      = base_r[1:0];
                            left_nxt     = `PPL_DATA_WORDS;
                            job_data_nxt = 1'b1;
                            state_nxt    = PPL_PRIME;
                        end else begin
                            // rewriting the same words and revision is
                            // harmless, so a repeat load changes nothing
                            active_nxt = 1'b1;
                            rev_nxt    = hdr_rev_r;
                            req_nxt    = 1'b0;
                            state_nxt  = PPL_IDLE;
                        end
                    end
                end
            end
            default: begin
                req_nxt   = 1'b0;
                state_nxt = PPL_IDLE;
            end
        endcase
        // INIT keeps what was applied and drops an unfinished fetch, except on the last data ack: the patch applies without that store write
        if (i_soft_init) begin
            req_nxt   = 1'b0;
            state_nxt = PPL_IDLE;
            ucode_nxt = '0;
        end
        busy_nxt = state_nxt != PPL_IDLE;
    end

    // hard reset returns to unpatched, revision zero
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_r    <= PPL_IDLE;
            job_data_r <= 1'b0;
            base_r     <= 32'h0000_0000;
            addr_r     <= 32'h0000_0000;
            ofs_r      <= 2'h0;
            left_r     <= 9'h000;
            prev_r     <= 32'h0000_0000;
            hdr_rev_r  <= 32'h0000_0000;
            req_r      <= 1'b0;
            ucode_r    <= '0;
            active_r   <= 1'b0;
            rev_r      <= 32'h0000_0000;
            busy_r     <= 1'b0;
            rvalid_r   <= 1'b0;
            rdata_r    <= 64'h0000_0000_0000_0000;
            fault_r    <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            job_data_r <= job_data_nxt;
            base_r     <= base_nxt;
            addr_r     <= addr_nxt;
            ofs_r      <= ofs_nxt;
            left_r     <= left_nxt;
            prev_r     <= prev_nxt;
            hdr_rev_r  <= hdr_rev_nxt;
            req_r      <= req_nxt;
            ucode_r    <= ucode_nxt;
            active_r   <= active_nxt;
            rev_r      <= rev_nxt;
            busy_r     <= busy_nxt;
            rvalid_r   <= rvalid_nxt;
            rdata_r    <= rdata_nxt;
            fault_r    <= fault_nxt;
        end
    end

    assign o_mreg_rvalid  = rvalid_r;
    assign o_mreg_rdata   = rdata_r;
    assign o_mreg_fault   = fault_r;
    assign o_mem_req      = req_r;
    assign o_mem_addr     = addr_r;
    assign o_ucode_wr     = ucode_r;
    assign o_busy         = busy_r;
    assign o_patch_active = active_r;
    assign o_patch_rev    = rev_r;

endmodule : ppl_loader

`default_nettype wire

// File: tb/ppl_loader_checker.sv
// ppl_loader_checker: port timing checks for the patch loader.
// assumes one core clock and the loader's async hard reset.
`timescale 1ns/1ps
`default_nettype none
`include "ppl_map.svh"

module ppl_loader_checker
    import ppl_pkg::*;
(
    // watched ports
    input wire logic          i_clock,
    input wire logic          i_rst,
    input wire logic          i_soft_init,
    input wire ppl_mreg_req_s i_mreg,
    input wire logic          i_ident_query,
    input wire logic          o_mreg_rvalid,
    input wire logic [63:0]   o_mreg_rdata,
    input wire logic          o_mreg_fault,
    input wire logic          o_mem_req,
    input wire logic [31:0]   o_mem_addr,
    input wire logic          i_mem_ack,
    input wire ppl_ucode_wr_s o_ucode_wr,
    input wire logic          o_busy,
    input wire logic          o_patch_active,
    input wire logic [31:0]   o_patch_rev
);
    logic [31:0] wd_r;

    // remembers the last written data so the first fetch can be judged
    always_ff @(posedge i_clock) wd_r <= i_mreg.wdata[31:0];

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence s_trig;
        i_mreg.wr && i_mreg.addr == `PPL_TRIG_ADDR && !o_busy && !i_soft_init;
    endsequence
    sequence s_query;
        i_ident_query && o_patch_active;
    endsequence
    sequence s_sig_rd;
        i_mreg.rd && i_mreg.addr == `PPL_SIG_ADDR;
    endsequence

    a_trig_start: assert property (s_trig |=> o_busy && o_mem_req)
        else $error("trigger write did not start a load");
    a_first_addr: assert property ($rose(o_busy) |->
        o_mem_addr == ((wd_r - 32'd44) & 32'hFFFF_FFFC))
        else $error("first fetch address wrong");
    a_word_addr: assert property (o_mem_req |-> o_mem_addr[1:0] == 2'b00)
        else $error("fetch address not word aligned");
    a_req_hold: assert property (o_mem_req && !i_mem_ack && !i_soft_init
        |=> o_mem_req && $stable(o_mem_addr))
        else $error("fetch request dropped or moved");
    a_ucode_cause: assert property (o_ucode_wr.valid |->
        $past(i_mem_ack) && o_ucode_wr.index <= 9'h1F3)
        else $error("store word without memory word");
    a_query_sig: assert property (s_query ##1 s_sig_rd |=>
        o_mreg_rvalid && o_mreg_rdata == {o_patch_rev, 32'h0})
        else $error("signature does not hold revision");
    a_soft_keep: assert property (i_soft_init && !o_busy |=>
        $stable(o_patch_rev) && $stable(o_patch_active))
        else $error("soft init changed the patch");
    a_soft_abort: assert property (i_soft_init |=> !o_mem_req && !o_busy)
        else $error("soft init did not stop the fetch");
    a_rev_zero: assert property (!o_patch_active |-> o_patch_rev == 32'h0)
        else $error("revision nonzero without patch");
    a_bad_read: assert property (i_mreg.rd && i_mreg.addr != `PPL_SIG_ADDR
        |=> o_mreg_fault && o_mreg_rdata == 64'h0)
        else $error("unmapped read not refused");
endmodule : ppl_loader_checker

bind ppl_loader ppl_loader_checker ppl_loader_checker_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_soft_init(i_soft_init),
    .i_mreg(i_mreg), .i_ident_query(i_ident_query),
    .o_mreg_rvalid(o_mreg_rvalid), .o_mreg_rdata(o_mreg_rdata),
    .o_mreg_fault(o_mreg_fault), .o_mem_req(o_mem_req),
    .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack),
    .o_ucode_wr(o_ucode_wr), .o_busy(o_busy),
    .o_patch_active(o_patch_active), .o_patch_rev(o_patch_rev));
`default_nettype wire

// File: tb/ppl_mem_model.sv
// ppl_mem_model: memory behind the loader; byte at address b holds b[7:0].
// assumes word-aligned requests held until acknowledged.
`timescale 1ns/1ps
`default_nettype none

module ppl_mem_model (
    // clock and request
    input  wire logic        i_clock,
    input  wire logic        i_req,
    input  wire logic [31:0] i_addr,
    input  wire logic        i_slow,
    // answer
    output logic             o_ack,
    output logic      [31:0] o_rdata
);
    logic        tog_r = 1'b0;
    logic [31:0] word;

    always @(posedge i_clock) tog_r <= ~tog_r;
    assign word = {i_addr[7:0] + 8'h03, i_addr[7:0] + 8'h02,
                   i_addr[7:0] + 8'h01, i_addr[7:0]};
    assign o_ack = i_req && (!i_slow || tog_r);
    // no ack means garbage on the data lines, never the last word
    assign o_rdata = o_ack ? word : ~word;
endmodule : ppl_mem_model
`default_nettype wire

// File: tb/ppl_loader_bench.sv
// ppl_loader_bench: self-checking bench for the patch loader.
// assumes ppl_mem_model stands in for memory; drives at falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "ppl_map.svh"

module ppl_loader_bench;
    import ppl_pkg::*;
    logic          i_clock, i_rst, i_soft_init, i_ident_query, mem_slow;
    logic          o_mreg_rvalid, o_mreg_fault, o_mem_req, o_busy;
    logic          o_patch_active, i_mem_ack, rd_f;
    logic [63:0]   o_mreg_rdata, rd_v, sig_v;
    logic [31:0]   o_mem_addr, i_mem_rdata, o_patch_rev;
    ppl_mreg_req_s i_mreg;
    ppl_ucode_wr_s o_ucode_wr;
    int            error_cnt = 0;
    int            num_checks = 0;

    ppl_loader ppl_loader_i (.i_clock(i_clock), .i_rst(i_rst),
        .i_soft_init(i_soft_init), .i_mreg(i_mreg),
        .i_ident_query(i_ident_query), .o_mreg_rvalid(o_mreg_rvalid),
        .o_mreg_rdata(o_mreg_rdata), .o_mreg_fault(o_mreg_fault),
        .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
        .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
        .o_ucode_wr(o_ucode_wr), .o_busy(o_busy),
        .o_patch_active(o_patch_active), .o_patch_rev(o_patch_rev));
    ppl_mem_model ppl_mem_model_i (.i_clock(i_clock), .i_req(o_mem_req),
        .i_addr(o_mem_addr), .i_slow(mem_slow), .o_ack(i_mem_ack),
        .o_rdata(i_mem_rdata));

    function automatic logic [31:0] exp_word(input logic [31:0] b);
        return {b[7:0] + 8'h03, b[7:0] + 8'h02, b[7:0] + 8'h01, b[7:0]};
    endfunction : exp_word

    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask : chk

    task automatic results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results

    task automatic reg_wr(input logic [31:0] a, input logic [63:0] d);
        @(negedge i_clock);
        i_mreg.wr = 1'b1;
        i_mreg.addr = a;
        i_mreg.wdata = d;
        @(negedge i_clock);
        i_mreg.wr = 1'b0;
    endtask : reg_wr

    // also ends a query raised just before, so query and read abut
    task automatic reg_rd(input logic [31:0] a);
        @(negedge i_clock);
        i_ident_query = 1'b0;
        i_mreg.rd = 1'b1;
        i_mreg.addr = a;
        @(negedge i_clock);
        i_mreg.rd = 1'b0;
        rd_v = o_mreg_rdata;
        rd_f = o_mreg_fault;
        chk(o_mreg_rvalid === 1'b1, "read not answered");
    endtask : reg_rd

    task automatic get_sig;
        reg_wr(`PPL_SIG_ADDR, 64'h0);
        @(negedge i_clock);
        i_ident_query = 1'b1;
        reg_rd(`PPL_SIG_ADDR);
    endtask : get_sig

    task automatic load(input logic [31:0] a, input logic slow);
        int n;
        int k;
        n = 0;
        mem_slow = slow;
        reg_wr(`PPL_TRIG_ADDR, {32'h0, a});
        for (k = 0; k < 3000; k++) begin
            if (o_ucode_wr.valid === 1'b1) begin
                chk(o_ucode_wr.index === 9'(n) && o_ucode_wr.data ===
                    exp_word(a + 32'(4 * n)), "patch word");
                n++;
            end
            if (o_busy !== 1'b1) break;
            @(negedge i_clock);
        end
        if (k == 3000) begin
            chk(1'b0, "load timed out");
            results();
        end
        chk(n == 500, "patch word count");
        chk(o_patch_active === 1'b1 && o_patch_rev === exp_word(a - 32'd44),
            "active revision");
    endtask : load

    task automatic t_no_patch;
        chk(o_patch_active === 1'b0 && o_patch_rev === 32'h0, "reset");
        get_sig();
        chk(rd_v === 64'h0, "no patch signature");
        reg_wr(32'h0000_0010, 64'h0);
        chk(o_mreg_fault === 1'b1, "unmapped write");
        reg_wr(`PPL_SIG_ADDR, 64'h1234_5678_9ABC_DEF0);
        @(negedge i_clock);
        i_ident_query = 1'b1;
        reg_rd(`PPL_SIG_ADDR);
        chk(rd_v === 64'h1234_5678_9ABC_DEF0, "query altered");
        reg_rd(`PPL_TRIG_ADDR);
        chk(rd_f === 1'b1 && rd_v === 64'h0, "trigger read");
    endtask : t_no_patch

    task automatic t_load_verify;
        load(32'h0000_1003 + 32'h0000_0030, 1'b1);
        get_sig();
        sig_v = {exp_word(32'h0000_1007), 32'h0};
        chk(rd_v === sig_v, "signature");
        reg_rd(`PPL_SIG_ADDR);
        chk(rd_v === sig_v && o_patch_active === 1'b1, "reread");
    endtask : t_load_verify

    task automatic t_reload;
        load(32'h0000_2230, 1'b0);
        load(32'h0000_2230, 1'b0);
        get_sig();
        chk(rd_v === {32'h0706_0504, 32'h0}, "second load");
    endtask : t_reload

    task automatic t_soft_init;
        reg_wr(`PPL_TRIG_ADDR, {32'h0, 32'h0000_3031});
        repeat (5) @(negedge i_clock);
        i_soft_init = 1'b1;
        @(negedge i_clock);
        i_soft_init = 1'b0;
        chk(o_busy === 1'b0 && o_patch_rev === 32'h0706_0504, "init");
        reg_rd(`PPL_SIG_ADDR);
        chk(rd_v === {32'h0706_0504, 32'h0}, "init signature");
    endtask : t_soft_init

    task automatic t_hard_reset;
        @(negedge i_clock);
        i_rst = 1'b1;
        repeat (12) @(negedge i_clock);
        i_rst = 1'b0;
        chk(o_patch_active === 1'b0 && o_patch_rev === 32'h0, "hard");
        reg_rd(`PPL_SIG_ADDR);
        chk(rd_v === 64'h0, "hard signature");
        load(32'h0000_4000 + 32'h0000_0030, 1'b0);
    endtask : t_hard_reset

    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end

    initial begin
        i_rst = 1'b1;
        i_soft_init = 1'b0;
        i_ident_query = 1'b0;
        mem_slow = 1'b0;
        i_mreg = '0;
        repeat (12) @(negedge i_clock);
        i_rst = 1'b0;
        // no-patch checks come first, then the loads; flat addresses
        // one processor
        t_no_patch();
        t_load_verify();
        t_reload();
        t_soft_init();
        t_hard_reset();
        results();
    end
endmodule : ppl_loader_bench
`default_nettype wire
